//--- rate_gen.sv
// Prescaler and bit-rate divider producing half-period ticks of the transfer clock.
// Assumes run is held high for the whole time ticks are wanted.
`timescale 1ns/1ps
module rate_gen
    import sync_serial_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Configuration
    input  wire logic [1:0] src_sel,
    input  wire logic       half_sel,
    input  wire logic [7:0] divider,
    input  wire logic       run,
    // Half-period tick
    output logic            tick
);

    logic [4:0] pre_ff;
    logic [4:0] nxt_pre;
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic       tick_ff;
    logic       nxt_tick;
    logic       src_tick;

    always_comb begin
        nxt_pre = pre_ff + 5'h01;
        case (src_sel)
            SRC_DIV1_2: src_tick = half_sel ? (pre_ff[0] == PRE_DIV2_END[0]) : 1'b1;
            SRC_DIV8:   src_tick = (pre_ff[2:0] == PRE_DIV8_END[2:0]);
            SRC_DIV32:  src_tick = (pre_ff == PRE_DIV32_END);
            // Forbidden code: clock simply stops
            default:    src_tick = 1'b0;
        endcase
        nxt_div  = div_ff;
        nxt_tick = 1'b0;
        if (!run) begin
            nxt_div = 8'h00;
        end else if (src_tick) begin
            // Toggle every n+1 source ticks gives f/(2(n+1))
            if (div_ff == divider) begin
                nxt_div  = 8'h00;
                nxt_tick = 1'b1;
            end else begin
                nxt_div = div_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pre_ff  <= 5'h00;
            div_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            div_ff  <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule

//--- serial_peer.sv
// Behavioural serial peer for the synchronous serial port.
// Assumes the bench resolves the clock and data-out wires and restarts it per byte.
`timescale 1ns/1ps
module serial_peer (
    // Clock
    input  wire logic       clock,
    // Bench control
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    input  wire logic       msb_first,
    input  wire logic       polarity,
    input  wire logic       ext_go,
    input  wire logic [7:0] ext_half,
    // Serial wires
    input  wire logic       clk_line,
    input  wire logic       data_line,
    output logic            peer_clk,
    output logic            peer_sin,
    output logic      [7:0] rx_byte
);
    logic       line_q;
    logic [3:0] idx;
    logic       rise;
    logic       fall;

    assign rise = ~line_q & clk_line;
    assign fall = line_q & ~clk_line;

    function automatic logic [2:0] pos(input logic [3:0] i);
        return msb_first ? 3'(7 - i) : i[2:0];
    endfunction

    initial begin
        peer_clk = 1'b1;
        line_q   = 1'b1;
        idx      = 4'h8;
        peer_sin = 1'b0;
        rx_byte  = 8'h00;
    end

    // Edges seen one cycle late, so half periods below 2 cycles are not supported
    always @(posedge clock) begin
        line_q <= clk_line;
        if (start) begin
            idx      <= 4'h0;
            peer_sin <= tx_byte[pos(4'h0)];
        end else if ((polarity ? fall : rise) && idx < 4'h8) begin
            rx_byte[pos(idx)] <= data_line;
            idx               <= idx + 4'h1;
        end else if ((polarity ? rise : fall) && idx < 4'h8 && idx != 4'h0) begin
            peer_sin <= tx_byte[pos(idx)];
        end
    end

    // Exactly eight pulses, then the clock rests high
    always @(posedge clock) begin
        if (ext_go) begin
            repeat (16) begin
                repeat (ext_half) @(posedge clock);
                peer_clk <= ~peer_clk;
            end
        end
    end
endmodule

//--- sync_serial_pkg.sv
// Shared constants, control layout and state codes for the synchronous serial port.
// Assumes a single 100 MHz clock and a byte-wide register port.
package sync_serial_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [9:0] OFF_CONTROL = 10'h1E2;
    localparam logic [9:0] OFF_DIVIDER = 10'h1E3;
    localparam logic [9:0] OFF_DATA    = 10'h1E0;

    localparam logic [7:0] RST_CONTROL = 8'h40;
    localparam logic [7:0] RST_DIVIDER = 8'h00;
    localparam logic [7:0] RST_DATA    = 8'h00;

    // ****************************************
    // Clock source codes and prescaler terminals
    // ****************************************
    localparam logic [1:0] SRC_DIV1_2 = 2'h0;
    localparam logic [1:0] SRC_DIV8   = 2'h1;
    localparam logic [1:0] SRC_DIV32  = 2'h2;

    localparam logic [4:0] PRE_DIV2_END  = 5'h01;
    localparam logic [4:0] PRE_DIV8_END  = 5'h07;
    localparam logic [4:0] PRE_DIV32_END = 5'h1F;

    localparam logic [2:0] LAST_BIT = 3'h7;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic idle_level_select;
        logic clock_source_select;
        logic bit_order_select;
        logic clock_polarity_select;
        logic port_function_select;
        logic data_out_disable;
        logic clk_source_sel_hi;
        logic clk_source_sel_lo;
    } ctrl_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_HOLD = 3'b100
    } xfer_state_e;

endpackage

//--- sync_serial_port.sv
// Clock-synchronous 8-bit serial port: control, divider and shift/data registers.
// Assumes pins are synchronous to clock; pad logic resolves drive from the enables.
`timescale 1ns/1ps
// Operation
// - Source code 00 picks div1/div2, 01 div8, 10 div32; 11 forbidden.
// - Div1 versus div2 for code 00 comes from an outside select bit.
// - Output disable set floats the data-out pin in every pin function.
// - Port select 1 hands data-out and clock pins to the serial unit.
// - Polarity 0 shifts out on falling, samples on rising; 1 swaps.
// - Bit order 0 is LSB first, 1 is MSB first, both directions.
// - Clock select 0 takes clock from pin; 1 generates and drives it.
// - With port select 0 the data-out pin shows the idle-level bit.
// - External clock: idle level held, last bit kept between back-to-back bytes.
// - Internal transfer clock is source divided by 2(n+1).
// - Each transfer moves eight bits out and in together.
// - Writing the shift/data register starts a transfer.
// - Completion is flagged on the last rising edge, or falling with polarity 1.
// - Shifting follows every clock edge; internal clock stops after eight.
// - Internal clock: last bit held half a period, then float; write floats now.
// - Internal clock rests high for polarity 0, low for polarity 1.
module sync_serial_port
    import sync_serial_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [9:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Outside clock select
    input  wire logic       periph_clk_half_select,
    // Serial pins
    input  wire logic       serial_clock_in,
    output logic            serial_clock_out,
    output logic            serial_clock_oe,
    output logic            serial_out_pin,
    output logic            serial_out_oe,
    input  wire logic       serial_in_pin,
    // Completion request
    output logic            xfer_done
);

    // ****************************************
    // Register state
    // ****************************************
    ctrl_s       ctrl_ff;
    ctrl_s       nxt_ctrl;
    logic [7:0]  divider_ff;
    logic [7:0]  nxt_divider;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;

    // ****************************************
    // Transfer engine state
    // ****************************************
    xfer_state_e state_ff;
    xfer_state_e nxt_state;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic [2:0]  bit_cnt_ff;
    logic [2:0]  nxt_bit_cnt;
    logic        out_level_ff;
    logic        nxt_out_level;
    logic        drive_ff;
    logic        nxt_drive;
    logic        clk_level_ff;
    logic        nxt_clk_level;
    logic        clk_prev_ff;
    logic        done_ff;
    logic        nxt_done;
    logic        sout_ff;
    logic        nxt_sout;
    logic        sout_oe_ff;
    logic        nxt_sout_oe;
    logic        clk_oe_ff;
    logic        nxt_clk_oe;

    logic        wr_ctrl;
    logic        wr_data;
    logic        int_clk;
    logic        tick;
    logic        out_edge;
    logic        sample_edge;
    logic        ext_rise;
    logic        ext_fall;

    assign wr_ctrl = reg_wr && (reg_addr == OFF_CONTROL);
    assign wr_data = reg_wr && (reg_addr == OFF_DATA);
    assign int_clk = ctrl_ff.clock_source_select;

    rate_gen u_rate_gen (
        .clock    (clock),
        .reset_n  (reset_n),
        .src_sel  ({ctrl_ff.clk_source_sel_hi, ctrl_ff.clk_source_sel_lo}),
        .half_sel (periph_clk_half_select),
        .divider  (divider_ff),
        .run      (int_clk && (state_ff != ST_IDLE)),
        .tick     (tick)
    );

    // ****************************************
    // Register port
    // ****************************************
    always_comb begin
        nxt_ctrl    = ctrl_ff;
        nxt_divider = divider_ff;
        nxt_rdata   = 8'h00;
        if (wr_ctrl) begin
            nxt_ctrl = ctrl_s'(reg_wdata);
        end
        if (reg_wr && (reg_addr == OFF_DIVIDER)) begin
            nxt_divider = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                OFF_CONTROL: nxt_rdata = ctrl_ff;
                OFF_DIVIDER: nxt_rdata = divider_ff;
                OFF_DATA:    nxt_rdata = shift_ff;
                default:     nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff    <= ctrl_s'(RST_CONTROL);
            divider_ff <= RST_DIVIDER;
            rdata_ff   <= 8'h00;
        end else begin
            ctrl_ff    <= nxt_ctrl;
            divider_ff <= nxt_divider;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ****************************************
    // Transfer engine
    // ****************************************
    assign ext_rise = serial_clock_in && !clk_prev_ff;
    assign ext_fall = !serial_clock_in && clk_prev_ff;

    always_comb begin
        nxt_state     = state_ff;
        nxt_shift     = shift_ff;
        nxt_bit_cnt   = bit_cnt_ff;
        nxt_out_level = out_level_ff;
        nxt_drive     = drive_ff;
        nxt_clk_level = clk_level_ff;
        nxt_done      = 1'b0;
        out_edge      = 1'b0;
        sample_edge   = 1'b0;
        if (int_clk) begin
            if (state_ff == ST_RUN && tick) begin
                nxt_clk_level = !clk_level_ff;
                // Leaving the rest level is the output edge
                out_edge      = (clk_level_ff == !ctrl_ff.clock_polarity_select);
                sample_edge   = !out_edge;
            end else if (state_ff != ST_RUN) begin
                nxt_clk_level = !ctrl_ff.clock_polarity_select;
            end
        end else if (ctrl_ff.port_function_select) begin
            // Shifts on every edge, even outside a transfer
            out_edge    = ctrl_ff.clock_polarity_select ? ext_rise : ext_fall;
            sample_edge = ctrl_ff.clock_polarity_select ? ext_fall : ext_rise;
        end
        if (out_edge) begin
            nxt_out_level = ctrl_ff.bit_order_select ? shift_ff[7] : shift_ff[0];
            nxt_drive     = 1'b1;
        end
        if (sample_edge) begin
            if (ctrl_ff.bit_order_select) begin
                nxt_shift = {shift_ff[6:0], serial_in_pin};
            end else begin
                nxt_shift = {serial_in_pin, shift_ff[7:1]};
            end
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (state_ff == ST_RUN && bit_cnt_ff == LAST_BIT) begin
                nxt_done  = 1'b1;
                nxt_state = int_clk ? ST_HOLD : ST_IDLE;
            end
        end
        if (state_ff == ST_HOLD && tick) begin
            nxt_state = ST_IDLE;
            nxt_drive = 1'b0;
        end
        if (wr_ctrl) begin
            // Idle level is loaded only when written, so back-to-back bytes keep the last bit
            nxt_out_level = reg_wdata[7];
        end
        if (wr_data) begin
            nxt_shift   = reg_wdata;
            nxt_bit_cnt = 3'h0;
            nxt_state   = ST_RUN;
            if (int_clk) begin
                nxt_drive = 1'b0;
            end
        end
        if (!ctrl_ff.port_function_select) begin
            nxt_sout   = ctrl_ff.idle_level_select;
            nxt_clk_oe = 1'b0;
        end else begin
            nxt_sout   = nxt_out_level;
            nxt_clk_oe = int_clk;
        end
        nxt_sout_oe = !ctrl_ff.data_out_disable &&
                      (!ctrl_ff.port_function_select || !int_clk || nxt_drive);
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_ff     <= ST_IDLE;
            shift_ff     <= RST_DATA;
            bit_cnt_ff   <= 3'h0;
            out_level_ff <= 1'b0;
            drive_ff     <= 1'b0;
            clk_level_ff <= 1'b1;
            clk_prev_ff  <= 1'b1;
            done_ff      <= 1'b0;
            sout_ff      <= 1'b0;
            sout_oe_ff   <= 1'b0;
            clk_oe_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            shift_ff     <= nxt_shift;
            bit_cnt_ff   <= nxt_bit_cnt;
            out_level_ff <= nxt_out_level;
            drive_ff     <= nxt_drive;
            clk_level_ff <= nxt_clk_level;
            clk_prev_ff  <= serial_clock_in;
            done_ff      <= nxt_done;
            sout_ff      <= nxt_sout;
            sout_oe_ff   <= nxt_sout_oe;
            clk_oe_ff    <= nxt_clk_oe;
        end
    end

    assign reg_rdata        = rdata_ff;
    assign serial_clock_out = clk_level_ff;
    assign serial_clock_oe  = clk_oe_ff;
    assign serial_out_pin   = sout_ff;
    assign serial_out_oe    = sout_oe_ff;
    assign xfer_done        = done_ff;

    // ****************************************
    // Checks
    // ****************************************
    a_out_disable_float: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl_ff.data_out_disable |=> !serial_out_oe)
        else $error("data-out driven while disabled");

    a_port_clock_free: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrl_ff.port_function_select |=> !serial_clock_oe)
        else $error("clock pin driven in port mode");

    a_port_idle_level: assert property (@(posedge clock) disable iff (!reset_n)
        !ctrl_ff.port_function_select |=> serial_out_pin == $past(ctrl_ff.idle_level_select))
        else $error("port mode data-out level wrong");

    a_clock_rest_level: assert property (@(posedge clock) disable iff (!reset_n)
        // Rest level follows a polarity change one cycle late, so a just-changed polarity is skipped
        (int_clk && state_ff == ST_IDLE) ##1 (int_clk && state_ff == ST_IDLE && $stable(ctrl_ff.clock_polarity_select))
        |-> serial_clock_out == !ctrl_ff.clock_polarity_select)
        else $error("internal clock not at rest level");

    a_write_starts: assert property (@(posedge clock) disable iff (!reset_n)
        wr_data |=> state_ff == ST_RUN && bit_cnt_ff == 3'h0)
        else $error("data write did not start transfer");

    a_done_eighth_bit: assert property (@(posedge clock) disable iff (!reset_n)
        xfer_done |-> $past(bit_cnt_ff) == LAST_BIT && $past(state_ff) == ST_RUN)
        else $error("completion not on eighth sample");

    a_done_on_edge: assert property (@(posedge clock) disable iff (!reset_n)
        (xfer_done && int_clk && $past(int_clk)) |-> serial_clock_out == !ctrl_ff.clock_polarity_select)
        else $error("completion not on last sampling edge");

    a_hold_write_float: assert property (@(posedge clock) disable iff (!reset_n)
        (state_ff == ST_HOLD && wr_data && int_clk && ctrl_ff.port_function_select) |=> !serial_out_oe)
        else $error("write during hold did not float data-out");

endmodule

//--- sync_serial_port_tb.sv
// Self-checking bench for the synchronous serial port with a serial peer.
// Assumes the package constants and the register port contract of the design.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sync_serial_port_tb;
    import sync_serial_pkg::*;
    logic       clock, reset_n, reg_wr, reg_rd, half_sel, sin, xfer_done;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rdv, p_tx, p_rx;
    logic       sclk_out, sclk_oe, sout_pin, sout_oe, peer_clk, clk_line;
    logic       p_start, p_go, p_msb, p_pol, sout_last, sout_line, sclk_q;
    int         err_total, checked, cyc, ntog, t2, t16;

    assign clk_line  = sclk_oe ? sclk_out : peer_clk;
    // Released data-out shows the inverse of its last level
    assign sout_line = sout_oe ? sout_pin : ~sout_last;
    always @(posedge clock) if (sout_oe) sout_last <= sout_pin;

    sync_serial_port u_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_clk_half_select(half_sel),
        .serial_clock_in(clk_line), .serial_clock_out(sclk_out), .serial_clock_oe(sclk_oe),
        .serial_out_pin(sout_pin), .serial_out_oe(sout_oe), .serial_in_pin(sin), .xfer_done(xfer_done));
    serial_peer u_peer (.clock(clock), .start(p_start), .tx_byte(p_tx), .msb_first(p_msb), .polarity(p_pol),
        .ext_go(p_go), .ext_half(8'h05), .clk_line(clk_line), .data_line(sout_line), .peer_clk(peer_clk),
        .peer_sin(sin), .rx_byte(p_rx));

    // ****************************************
    // Clock and edge monitor
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        cyc++;
        if (sclk_q !== sclk_out) begin
            ntog++;
            if (ntog == 2) t2 = cyc;
            if (ntog == 16) t16 = cyc;
        end
        sclk_q = sclk_out;
    end

    // ****************************************
    // Bus and helper tasks
    // ****************************************
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pulse_start(input logic [7:0] tx, input logic msb, input logic pol);
        @(posedge clock);
        p_tx <= tx; p_msb <= msb; p_pol <= pol; p_start <= 1'b1;
        @(posedge clock);
        p_start <= 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 6000; i++) begin
            @(posedge clock);
            #1;
            if (xfer_done === 1'b1) return;
        end
        err_total++;
        $display("[FAIL] %0t no completion", $time);
        stop_test();
    endtask
    function automatic logic [7:0] ctl(input logic [1:0] s, input logic ps, pol, msb, intc, idle, dis);
        ctrl_s c;
        c = '{idle, intc, msb, pol, ps, dis, s[1], s[0]};
        return c;
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(OFF_CONTROL, rdv); `CHK(rdv, RST_CONTROL)
        rd(OFF_DIVIDER, rdv); `CHK(rdv, RST_DIVIDER)
        rd(OFF_DATA, rdv);    `CHK(rdv, RST_DATA)
        rd(10'h1E1, rdv);     `CHK(rdv, 8'h00)
        `CHK(sclk_oe, 1'b0)
        `CHK({sout_oe, sout_pin}, 2'b10)
    endtask
    task automatic t_pins();
        wr(OFF_CONTROL, ctl(SRC_DIV8, 0, 0, 0, 1, 1, 0));
        @(posedge clock); #1;
        `CHK({sout_oe, sout_pin, sclk_oe}, 3'b110)
        wr(OFF_CONTROL, ctl(SRC_DIV8, 0, 0, 0, 1, 1, 1));
        @(posedge clock); #1;
        `CHK(sout_oe, 1'b0)
        rd(OFF_CONTROL, rdv); `CHK(rdv, ctl(SRC_DIV8, 0, 0, 0, 1, 1, 1))
    endtask
    task automatic t_int(input logic [1:0] s, input logic hs, input logic [7:0] n, input logic msb,
                         input logic pol, input logic early, input logic [7:0] tx);
        int hp, k;
        hp = (int'(n) + 1) * ((s == SRC_DIV8) ? 8 : (s == SRC_DIV32) ? 32 : (hs ? 2 : 1));
        half_sel <= hs;
        wr(OFF_CONTROL, ctl(s, 1, pol, msb, 1, 0, 0));
        wr(OFF_DIVIDER, n);
        pulse_start(~tx, msb, pol);
        ntog = 0;
        wr(OFF_DATA, tx);
        wait_done();
        `CHK({sclk_oe, sclk_out, sout_oe}, {1'b1, ~pol, 1'b1})
        // Peer sees the last sampling edge one cycle late
        @(posedge clock);
        @(negedge clock); #1;
        `CHK(ntog, 16)
        `CHK(t16 - t2, 14 * hp)
        `CHK(p_rx, tx)
        if (early) begin
            wr(OFF_DATA, tx);
            @(posedge clock); #1;
            `CHK(sout_oe, 1'b0)
            wait_done();
        end else begin
            k = 0;
            while (sout_oe === 1'b1 && k < hp + 5) begin
                @(posedge clock); #1;
                k++;
            end
            `CHK(k >= hp - 2 && k <= hp + 2, 1'b1)
            rd(OFF_DATA, rdv); `CHK(rdv, ~tx)
        end
    endtask
    task automatic t_ext();
        wr(OFF_CONTROL, ctl(SRC_DIV8, 1, 0, 0, 0, 1, 0));
        @(posedge clock); #1;
        `CHK({sout_oe, sout_pin, sclk_oe}, 3'b110)
        pulse_start(8'h3C, 0, 0);
        wr(OFF_DATA, 8'h5A);
        p_go <= 1'b1;
        @(posedge clock);
        p_go <= 1'b0;
        wait_done();
        repeat (20) @(posedge clock);
        #1;
        `CHK(p_rx, 8'h5A)
        `CHK({sout_oe, sout_pin}, 2'b10)
        rd(OFF_DATA, rdv); `CHK(rdv, 8'h3C)
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        err_total = 0; checked = 0; cyc = 0; ntog = 0; t2 = 0; t16 = 0; sclk_q = 1'b1;
        reset_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
        half_sel = 1'b0; p_start = 1'b0; p_go = 1'b0; p_msb = 1'b0; p_pol = 1'b0;
        p_tx = 8'h00; sout_last = 1'b0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_pins();
        t_int(SRC_DIV1_2, 0, 8'h03, 0, 0, 0, 8'h96);
        t_int(SRC_DIV1_2, 1, 8'h02, 1, 0, 0, 8'h4B);
        t_int(SRC_DIV8, 0, 8'h00, 0, 1, 0, 8'hE1);
        t_int(SRC_DIV32, 0, 8'h01, 1, 1, 1, 8'h3C);
        t_int(SRC_DIV8, 0, 8'h01, 1, 0, 0, 8'h81);
        t_ext();
        stop_test();
    end
endmodule
